// [rtl/mccs_params.svh]
// How it works
// - plain machine cycle runs four quarters, one clock each, first to fourth.
// - stretched cycle runs first three quarters then two fourth quarters.
// - when enabled, only the fourth quarter of eligible cycles doubles.
// - during both extended quarters phase stays fourth and memory control and status outputs hold.
// - stretch enable lives in the setup register at its fixed address, read/write.
// - enable is bit 4; zero means normal, one means stretch.
// - reset clears the enable bit.
// - every address cycle of a memory sequence is stretched when enabled.
// - read-data cycle of a read-modify-write sequence is stretched when enabled.
// - host default cycles are never stretched.
// - processor default cycles are never stretched.
// - page-mode indication plays no part in the stretch decision.
// - every other memory subcycle keeps four quarters.
// - video timing follows its own clock, never paused by a stretch.
// - a stretched cycle is exactly one quarter longer than normal.
// - address cycles drive a bus-status code on the four status lines.
`ifndef MCCS_PARAMS_SVH
`define MCCS_PARAMS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define MCCS_SETUP_ADDR 32'hC00001A0
`define MCCS_SETUP_RST 32'h00000000
`define MCCS_STRETCH_BIT 4

// ----------------------------------------
// cycle shape and widths
// ----------------------------------------
`define MCCS_NORMAL_QUARTERS 4'h4
`define MCCS_STRETCH_QUARTERS 4'h5
`define MCCS_FIRST_QUARTER 4'h1
`define MCCS_CTL_W 8
`define MCCS_STATUS_W 4
`define MCCS_STATUS_IDLE 4'h0
`define MCCS_VID_W 16

`endif

// [rtl/mccs_pkg.sv]
package mccs_pkg;

  // ----------------------------------------
  // quarter phases and cycle kinds
  // ----------------------------------------
  typedef enum logic [1:0] {PH_FIRST, PH_SECOND, PH_THIRD, PH_FOURTH} mccs_phase_t;

  typedef enum logic [2:0] {
    KIND_ADDR,
    KIND_READ_DATA,
    KIND_WRITE_DATA,
    KIND_HOST_DEFAULT,
    KIND_CPU_DEFAULT,
    KIND_OTHER
  } mccs_kind_t;

endpackage

// [rtl/mccs_setup_reg.sv]
`timescale 1ns/10ps
`include "mccs_params.svh"

module mccs_setup_reg
  import mccs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic stretch_enable_bit_o
);

  logic [31:0] setup;
  logic [31:0] next_setup;
  logic [31:0] next_rdata;
  logic hit;

  // ----------------------------------------
  // decode and storage
  // ----------------------------------------
  always_comb
  begin
    hit = (reg_addr_i == `MCCS_SETUP_ADDR);
    next_setup = setup;
    next_rdata = 32'h00000000;
    if (reg_wr_i && hit)
    begin
      next_setup = reg_wdata_i;
    end
    if (reg_rd_i && hit)
    begin
      next_rdata = setup;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      setup <= `MCCS_SETUP_RST;
      reg_rdata_o <= 32'h00000000;
    end
    else
    begin
      setup <= next_setup;
      reg_rdata_o <= next_rdata;
    end
  end

  assign stretch_enable_bit_o = setup[`MCCS_STRETCH_BIT];

endmodule

// [rtl/mccs_phase_seq.sv]
`timescale 1ns/10ps
`include "mccs_params.svh"

module mccs_phase_seq
  import mccs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic stretch_i,
  output mccs_phase_t phase_o,
  output logic ext_first_o,
  output logic ext_second_o
);

  mccs_phase_t next_phase;
  logic next_ext_first;
  logic next_ext_second;

  // ----------------------------------------
  // quarter sequencer
  // ----------------------------------------
  always_comb
  begin
    next_phase = phase_o;
    next_ext_first = 1'b0;
    next_ext_second = 1'b0;
    unique case (phase_o)
      PH_FIRST: next_phase = PH_SECOND;
      PH_SECOND: next_phase = PH_THIRD;
      PH_THIRD:
      begin
        next_phase = PH_FOURTH;
        next_ext_first = stretch_i;
      end
      PH_FOURTH:
      begin
        if (ext_first_o)
        begin
          // hold the core in the fourth quarter for one more clock
          next_phase = PH_FOURTH;
          next_ext_second = 1'b1;
        end
        else
        begin
          next_phase = PH_FIRST;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      phase_o <= PH_FIRST;
      ext_first_o <= 1'b0;
      ext_second_o <= 1'b0;
    end
    else
    begin
      phase_o <= next_phase;
      ext_first_o <= next_ext_first;
      ext_second_o <= next_ext_second;
    end
  end

endmodule

// [rtl/mccs_top.sv]
`timescale 1ns/10ps
`include "mccs_params.svh"

module mccs_top
  import mccs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [2:0] cyc_kind_i,
  input wire logic rmw_i,
  input wire logic page_mode_i,
  input wire logic [3:0] bus_status_code_i,
  input wire logic [7:0] mem_ctl_i,
  input wire logic video_clock_input_i,
  output logic [31:0] reg_rdata_o,
  output mccs_phase_t phase_o,
  output logic extended_phase_first_o,
  output logic extended_phase_second_o,
  output logic stretch_active_o,
  output logic stretch_enable_bit_o,
  output logic [3:0] bus_status_lines_o,
  output logic [7:0] mem_ctl_o,
  output logic [15:0] video_ticks_o
);

  // ----------------------------------------
  // setup register and sequencer
  // ----------------------------------------
  mccs_setup_reg u_setup (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .stretch_enable_bit_o(stretch_enable_bit_o)
  );

  logic stretch_cur;
  mccs_phase_seq u_seq (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .stretch_i(stretch_cur),
    .phase_o(phase_o),
    .ext_first_o(extended_phase_first_o),
    .ext_second_o(extended_phase_second_o)
  );

  // ----------------------------------------
  // stretch decision, made once per cycle
  // ----------------------------------------
  logic last_q;
  logic eligible;
  logic next_stretch_cur;
  mccs_kind_t kind_in;
  mccs_kind_t kind_cur;
  mccs_kind_t next_kind_cur;

  always_comb
  begin
    last_q = (phase_o == PH_FOURTH) && !extended_phase_first_o;
    kind_in = mccs_kind_t'(cyc_kind_i);
    // page_mode_i is deliberately not consulted
    unique case (kind_in)
      KIND_ADDR: eligible = 1'b1;
      KIND_READ_DATA: eligible = rmw_i;
      KIND_WRITE_DATA: eligible = 1'b0;
      KIND_HOST_DEFAULT: eligible = 1'b0;
      KIND_CPU_DEFAULT: eligible = 1'b0;
      default: eligible = 1'b0;
    endcase
    next_stretch_cur = stretch_cur;
    next_kind_cur = kind_cur;
    if (last_q)
    begin
      // sampled only at the boundary so a running cycle never changes shape
      next_stretch_cur = stretch_enable_bit_o && eligible;
      next_kind_cur = kind_in;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      stretch_cur <= 1'b0;
      kind_cur <= KIND_OTHER;
    end
    else
    begin
      stretch_cur <= next_stretch_cur;
      kind_cur <= next_kind_cur;
    end
  end

  // ----------------------------------------
  // frozen device outputs
  // ----------------------------------------
  logic [7:0] next_mem_ctl;
  logic [3:0] next_status;
  logic next_active;

  always_comb
  begin
    next_mem_ctl = mem_ctl_o;
    next_status = bus_status_lines_o;
    next_active = stretch_cur;
    // skipping the load on the first extension edge keeps the fourth-quarter values frozen
    if (!extended_phase_first_o)
    begin
      next_mem_ctl = mem_ctl_i;
      // next kind, so the code shows from the first quarter of an address cycle, not one late
      next_status = (next_kind_cur == KIND_ADDR) ? bus_status_code_i : `MCCS_STATUS_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      mem_ctl_o <= 8'h00;
      bus_status_lines_o <= `MCCS_STATUS_IDLE;
      stretch_active_o <= 1'b0;
    end
    else
    begin
      mem_ctl_o <= next_mem_ctl;
      bus_status_lines_o <= next_status;
      stretch_active_o <= next_active;
    end
  end

  // ----------------------------------------
  // video tick counter, never gated by the stretch
  // ----------------------------------------
  logic vid_s1;
  logic vid_s2;
  logic vid_s3;
  logic [15:0] next_ticks;

  always_comb
  begin
    next_ticks = video_ticks_o;
    if (vid_s2 && !vid_s3)
    begin
      next_ticks = video_ticks_o + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      vid_s1 <= 1'b0;
      vid_s2 <= 1'b0;
      vid_s3 <= 1'b0;
      video_ticks_o <= 16'h0000;
    end
    else
    begin
      vid_s1 <= video_clock_input_i;
      vid_s2 <= vid_s1;
      vid_s3 <= vid_s2;
      video_ticks_o <= next_ticks;
    end
  end

  // ----------------------------------------
  // quarter count per machine cycle, checking aid
  // ----------------------------------------
  logic [3:0] qlen;
  logic [3:0] next_qlen;

  always_comb
  begin
    next_qlen = last_q ? `MCCS_FIRST_QUARTER : qlen + 4'h1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      qlen <= `MCCS_FIRST_QUARTER;
    end
    else
    begin
      qlen <= next_qlen;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  property p_plain_cycle;
    (phase_o == PH_FIRST) && !stretch_cur |=> (phase_o == PH_SECOND) ##1 (phase_o == PH_THIRD)
      ##1 (phase_o == PH_FOURTH) && !extended_phase_first_o ##1 (phase_o == PH_FIRST);
  endproperty
  a_plain_cycle: assert property (p_plain_cycle) else $error("plain cycle not four quarters");

  property p_stretch_cycle;
    (phase_o == PH_THIRD) && stretch_cur |=> extended_phase_first_o && (phase_o == PH_FOURTH)
      ##1 extended_phase_second_o && (phase_o == PH_FOURTH) ##1 (phase_o == PH_FIRST);
  endproperty
  a_stretch_cycle: assert property (p_stretch_cycle) else $error("stretched cycle shape wrong");

  property p_only_fourth;
    (extended_phase_first_o || extended_phase_second_o) |-> (phase_o == PH_FOURTH) && stretch_cur;
  endproperty
  a_only_fourth: assert property (p_only_fourth) else $error("extension outside fourth quarter");

  property p_frozen;
    extended_phase_second_o |-> $stable(mem_ctl_o) && $stable(bus_status_lines_o);
  endproperty
  a_frozen: assert property (p_frozen) else $error("outputs moved during extension");

  property p_enable_write;
    reg_wr_i && (reg_addr_i == `MCCS_SETUP_ADDR)
      |=> stretch_enable_bit_o == $past(reg_wdata_i[`MCCS_STRETCH_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not written");

  property p_addr_stretch;
    last_q && stretch_enable_bit_o && (kind_in == KIND_ADDR) |=> ##3 extended_phase_first_o;
  endproperty
  a_addr_stretch: assert property (p_addr_stretch) else $error("address cycle not stretched");

  property p_rmw_stretch;
    last_q && stretch_enable_bit_o && (kind_in == KIND_READ_DATA) && rmw_i |=> stretch_cur;
  endproperty
  a_rmw_stretch: assert property (p_rmw_stretch) else $error("rmw read data not stretched");

  property p_no_stretch;
    last_q && (kind_in inside {KIND_HOST_DEFAULT, KIND_CPU_DEFAULT, KIND_WRITE_DATA})
      |=> !stretch_cur [*4];
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("ineligible cycle stretched");

  property p_length;
    last_q |-> qlen == (stretch_cur ? `MCCS_STRETCH_QUARTERS : `MCCS_NORMAL_QUARTERS);
  endproperty
  a_length: assert property (p_length) else $error("machine cycle length wrong");

  property p_boundary_only;
    !last_q |=> $stable(stretch_cur);
  endproperty
  a_boundary_only: assert property (p_boundary_only) else $error("stretch changed mid cycle");

  property p_video;
    vid_s2 && !vid_s3 |=> video_ticks_o == $past(video_ticks_o) + 16'h0001;
  endproperty
  a_video: assert property (p_video) else $error("video tick lost");

  property p_status;
    (next_kind_cur != KIND_ADDR) && !extended_phase_first_o |=> bus_status_lines_o == `MCCS_STATUS_IDLE;
  endproperty
  a_status: assert property (p_status) else $error("status code outside address cycle");

  property p_reset_clear;
    @(posedge sys_clk_i) disable iff (1'b0) srst_i |=> !stretch_enable_bit_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left enable set");

  property p_status_code;
    (next_kind_cur == KIND_ADDR) && !extended_phase_first_o |=> bus_status_lines_o == $past(bus_status_code_i);
  endproperty
  a_status_code: assert property (p_status_code) else $error("status code missing in address cycle");

  property p_active;
    1'b1 |=> stretch_active_o == $past(stretch_cur);
  endproperty
  a_active: assert property (p_active) else $error("stretch active flag wrong");

  property p_disabled;
    last_q && !stretch_enable_bit_o |=> !stretch_cur;
  endproperty
  a_disabled: assert property (p_disabled) else $error("stretch while disabled");

  property p_rdata_refused;
    reg_rd_i && (reg_addr_i != `MCCS_SETUP_ADDR) |=> reg_rdata_o == 32'h00000000;
  endproperty
  a_rdata_refused: assert property (p_rdata_refused) else $error("read of other address not zero");

  property p_reset_start;
    $fell(srst_i) |-> (phase_o == PH_FIRST) && !stretch_cur && !stretch_enable_bit_o;
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("bad state after reset");

  c_stretched: cover property (extended_phase_second_o);
  c_enabled_plain: cover property (stretch_enable_bit_o && last_q && !eligible);
  c_rmw: cover property (last_q && stretch_enable_bit_o && (kind_in == KIND_READ_DATA) && rmw_i);
  c_video_in_stretch: cover property (extended_phase_first_o && vid_s2 && !vid_s3);
  c_addr_code: cover property (last_q && (kind_in == KIND_ADDR) && stretch_enable_bit_o);

endmodule

// [testbench/mccs_mem_model.sv]
`timescale 1ns/10ps

module mccs_mem_model
(
  input wire logic sys_clk_i,
  output logic [2:0] cyc_kind_o,
  output logic rmw_o,
  output logic page_mode_o,
  output logic [3:0] bus_status_code_o,
  output logic [7:0] mem_ctl_o
);
  // ----------------------------------------
  // memory side sequence source
  // ----------------------------------------
  // a fresh kind every clock, codes 6 and 7 included, so any boundary can be hit by any kind
  integer seed;

  initial
  begin
    seed = 76;
    cyc_kind_o = 3'h0;
    rmw_o = 1'b0;
    page_mode_o = 1'b0;
    bus_status_code_o = 4'h0;
    mem_ctl_o = 8'h00;
  end

  always @(posedge sys_clk_i)
  begin
    cyc_kind_o <= 3'($random(seed));
    rmw_o <= 1'($random(seed));
    page_mode_o <= 1'($random(seed));
    bus_status_code_o <= 4'($random(seed));
    mem_ctl_o <= 8'($random(seed));
  end
endmodule

// [testbench/memory_cycle_clock_stretch_tb_top.sv]
`timescale 1ns/10ps
`include "mccs_params.svh"

module memory_cycle_clock_stretch_tb_top;
  logic sys_clk_i, srst_i, reg_wr_i, reg_rd_i, rmw_i, page_mode_i, video_clk, vid_run, run_chk, ext_a, ext_b, en_o;
  logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o, w;
  logic [2:0] cyc_kind_i;
  logic [3:0] bus_status_code_i, bus_status_lines_o, m_bus;
  logic [7:0] mem_ctl_i, mem_ctl_o, m_mem;
  logic [1:0] phase_o;
  logic [15:0] video_ticks_o;
  logic act_o;
  int n_mismatch, cmp_count, seed, vid_edges, n_str, m_ph, m_ext, m_st, m_kind, m_en, hold, m_act;

  mccs_top DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .cyc_kind_i(cyc_kind_i), .rmw_i(rmw_i),
    .page_mode_i(page_mode_i), .bus_status_code_i(bus_status_code_i), .mem_ctl_i(mem_ctl_i),
    .video_clock_input_i(video_clk), .reg_rdata_o(reg_rdata_o), .phase_o(phase_o),
    .extended_phase_first_o(ext_a), .extended_phase_second_o(ext_b), .stretch_active_o(act_o),
    .stretch_enable_bit_o(en_o), .bus_status_lines_o(bus_status_lines_o), .mem_ctl_o(mem_ctl_o),
    .video_ticks_o(video_ticks_o));

  mccs_mem_model mem (.sys_clk_i(sys_clk_i), .cyc_kind_o(cyc_kind_i), .rmw_o(rmw_i), .page_mode_o(page_mode_i),
    .bus_status_code_o(bus_status_code_i), .mem_ctl_o(mem_ctl_i));

  always #2 sys_clk_i = ~sys_clk_i;
  // video clock unrelated to the core clock; gated off before its count is compared
  always #11 video_clk = vid_run ? ~video_clk : 1'b0;
  always @(posedge video_clk) vid_edges = vid_edges + 1;

  // ----------------------------------------
  // reference model of the quarter sequencer
  // ----------------------------------------
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      m_ph = 0;
      m_ext = 0;
      m_st = 0;
      m_en = 0;
      m_kind = 5;
      m_act = 0;
      m_mem = 8'h00;
      m_bus = 4'h0;
    end
    else
    begin
      m_act = m_st;
      hold = (m_ext == 1);
      if (m_ph < 3)
      begin
        m_ph = m_ph + 1;
        m_ext = (m_ph == 3 && m_st) ? 1 : 0;
      end
      else if (hold)
        m_ext = 2;
      else
      begin
        m_ph = 0;
        m_ext = 0;
        m_kind = cyc_kind_i;
        m_st = m_en && (m_kind == 0 || (m_kind == 1 && rmw_i));
        n_str = n_str + m_st;
      end
      if (hold == 0)
      begin
        m_mem = mem_ctl_i;
        m_bus = (m_kind == 0) ? bus_status_code_i : 4'h0;
      end
      if (reg_wr_i && reg_addr_i == `MCCS_SETUP_ADDR)
        m_en = reg_wdata_i[`MCCS_STRETCH_BIT];
    end
  end

  // ----------------------------------------
  // checks and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(negedge sys_clk_i)
    if (run_chk)
    begin
      chk(32'(phase_o), 32'(m_ph));
      chk(32'({ext_a, ext_b}), 32'({m_ext == 1, m_ext == 2}));
      chk(32'(mem_ctl_o), 32'(m_mem));
      chk(32'(bus_status_lines_o), 32'(m_bus));
      chk(32'(en_o), 32'(m_en));
      chk(32'(act_o), 32'(m_act));
    end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(reg_rdata_o, e);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    sys_clk_i = 1'b0;
    srst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 32'h00000000;
    reg_wdata_i = 32'h00000000;
    video_clk = 1'b0;
    vid_run = 1'b0;
    run_chk = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    vid_edges = 0;
    n_str = 0;
    seed = 76;
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    run_chk <= 1'b1;
    vid_run = 1'b1;
    rd(`MCCS_SETUP_ADDR, 32'h00000000);
    wr(32'hC00001A4, 32'hFFFFFFFF);
    rd(`MCCS_SETUP_ADDR, 32'h00000000);
    rd(32'hC00001A4, 32'h00000000);
    repeat (60) @(posedge sys_clk_i);
    wr(`MCCS_SETUP_ADDR, 32'h00000010);
    rd(`MCCS_SETUP_ADDR, 32'h00000010);
    repeat (1000) @(posedge sys_clk_i);
    // enable flips at random points inside cycles, boundary sampling must absorb them
    repeat (40)
    begin
      w = $random(seed);
      wr(`MCCS_SETUP_ADDR, w);
      rd(`MCCS_SETUP_ADDR, w);
      repeat (w[10:8]) @(posedge sys_clk_i);
    end
    chk(32'(n_str > 20), 32'h00000001);
    vid_run = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    chk(32'(video_ticks_o), 32'(vid_edges[15:0]));
    wr(`MCCS_SETUP_ADDR, 32'h00000010);
    repeat (7) @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(`MCCS_SETUP_ADDR, 32'h00000000);
    repeat (40) @(posedge sys_clk_i);
    results;
  end

  initial
  begin
    #16000;
    n_mismatch = n_mismatch + 1;
    results;
  end
endmodule
